// File: cssg_cmd_if.sv
// interface: command port between the top and the register core
interface cssg_cmd_if;
  import cssg_pkg::*;
  logic        wr;
  logic        rd;
  cssg_sel_t   sel;
  logic [15:0] wdata;
  logic        clr_status;
  logic [15:0] cond;
  logic [15:0] event_only;
  logic [15:0] rdata;
  logic        summary;
  modport top  (output wr, rd, sel, wdata, clr_status, cond, event_only, input rdata, summary);
  modport core (input wr, rd, sel, wdata, clr_status, cond, event_only, output rdata, summary);
endinterface

// File: cssg_core.sv
// register core: condition, transition filters, event and enable registers
module cssg_core
  import cssg_pkg::*;
(
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rst,
  // command port
  cssg_cmd_if.core  cmd
);
  logic [15:0] cond_q;
  logic [15:0] ptr;
  logic [15:0] ntr;
  logic [15:0] evt;
  logic [15:0] ena;
  logic [15:0] cond_new;
  logic [15:0] next_evt;
  logic [15:0] next_ena;
  logic [15:0] set_bits;

  assign cond_new = cmd.cond & CSSG_COND_MASK;

  // per-bit edge filter and event-only latch
  for (genvar i = 0; i < CSSG_WIDTH; i++) begin : g_bit
    assign set_bits[i] = CSSG_COND_MASK[i]
                       ? ((cond_new[i] & ~cond_q[i] & ptr[i]) | (~cond_new[i] & cond_q[i] & ntr[i]))
                       : (CSSG_EVONLY_MASK[i] & cmd.event_only[i]);
  end

  always_comb begin
    next_evt = evt;
    if (cmd.clr_status || (cmd.rd && cmd.sel == CSSG_SEL_EVENT)) begin
      next_evt = '0;
    end
    next_evt = next_evt | set_bits; // set wins over clear
  end

  // enable after this edge, so the summary masks with the same enable the register will hold
  always_comb begin
    next_ena = ena;
    if (cmd.wr && cmd.sel == CSSG_SEL_ENABLE) begin
      next_ena = cmd.wdata & ~16'h8000;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cond_q <= CSSG_COND_RESET;
    end else begin
      cond_q <= cond_new;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      evt <= CSSG_EVT_RESET;
    end else begin
      evt <= next_evt;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ptr <= CSSG_PTR_RESET;
      ntr <= CSSG_NTR_RESET;
      ena <= CSSG_ENA_RESET;
    end else if (cmd.wr) begin
      unique case (cmd.sel)
        CSSG_SEL_PTR:    ptr <= cmd.wdata & ~16'h8000;
        CSSG_SEL_NTR:    ntr <= cmd.wdata & ~16'h8000;
        CSSG_SEL_ENABLE: ena <= next_ena;
        default: ;
      endcase
    end
  end

  // read data is the pre-clear value, registered
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cmd.rdata <= 16'h0000;
    end else if (cmd.rd) begin
      unique case (cmd.sel)
        CSSG_SEL_COND:   cmd.rdata <= cond_q;
        CSSG_SEL_PTR:    cmd.rdata <= ptr;
        CSSG_SEL_NTR:    cmd.rdata <= ntr;
        CSSG_SEL_EVENT:  cmd.rdata <= evt;
        CSSG_SEL_ENABLE: cmd.rdata <= ena;
        default:         cmd.rdata <= 16'h0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cmd.summary <= 1'b0;
    end else begin
      cmd.summary <= |(next_evt & next_ena);
    end
  end

  a_event_clear_read: assert property (@(posedge sys_clk) disable iff (rst)
    (cmd.rd && cmd.sel == CSSG_SEL_EVENT && !cmd.clr_status) |=> (evt == $past(set_bits)))
    else $error("event register not cleared by query");
  a_cstat_clears: assert property (@(posedge sys_clk) disable iff (rst)
    cmd.clr_status |=> (evt == $past(set_bits)))
    else $error("event register not cleared by clear-status");
  a_rise_latch: assert property (@(posedge sys_clk) disable iff (rst)
    ($rose(cond_q[CSSG_BIT_CONNECTED]) && $past(ptr[CSSG_BIT_CONNECTED])) |-> evt[CSSG_BIT_CONNECTED])
    else $error("filtered rising condition did not latch");
  a_fall_latch: assert property (@(posedge sys_clk) disable iff (rst)
    ($fell(cond_q[CSSG_BIT_RAMP]) && $past(ntr[CSSG_BIT_RAMP])) |-> evt[CSSG_BIT_RAMP])
    else $error("filtered falling condition did not latch");
  a_evonly_latch: assert property (@(posedge sys_clk) disable iff (rst)
    cmd.event_only[CSSG_BIT_PILOT] |=> evt[CSSG_BIT_PILOT])
    else $error("pilot event not latched");
  a_rsvd_zero: assert property (@(posedge sys_clk) disable iff (rst)
    !evt[CSSG_BIT_RSVD] && !cond_q[CSSG_BIT_RSVD] && !cmd.rdata[CSSG_BIT_RSVD])
    else $error("reserved bit set");
  a_summary_or: assert property (@(posedge sys_clk) disable iff (rst)
    ##1 (cmd.summary == |(evt & ena)))
    else $error("summary does not match masked events");
  a_enable_write: assert property (@(posedge sys_clk) disable iff (rst)
    (cmd.wr && cmd.sel == CSSG_SEL_ENABLE) |=> (ena == ($past(cmd.wdata) & 16'h7FFF)))
    else $error("enable write lost");
  a_cond_read: assert property (@(posedge sys_clk) disable iff (rst)
    (cmd.rd && cmd.sel == CSSG_SEL_COND) |=> (cmd.rdata == $past(cond_q)))
    else $error("condition read wrong");
endmodule

// File: cssg_ctrl_model.sv
// controller model: issues status commands on the command port
module cssg_ctrl_model
  import cssg_pkg::*;
(
  // clock
  input  wire logic        sys_clk,
  // command port
  output logic             cmd_wr,
  output logic             cmd_rd,
  output cssg_sel_t        cmd_sel,
  output logic [15:0]      cmd_wdata,
  output logic             clr_status,
  // answers
  input  wire logic [15:0] rdata
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    cmd_wr = 1'b0;
    cmd_rd = 1'b0;
    cmd_sel = CSSG_SEL_COND;
    cmd_wdata = 16'h0000;
    clr_status = 1'b0;
  end

  task automatic wr_reg(input cssg_sel_t s, input logic [15:0] d);
    @(negedge sys_clk);
    cmd_sel = s;
    cmd_wdata = d;
    cmd_wr = 1'b1;
    @(negedge sys_clk);
    cmd_wr = 1'b0;
    // released data must not keep its last value
    cmd_wdata = ~d;
  endtask

  task automatic rd_reg(input cssg_sel_t s, output logic [15:0] d);
    @(negedge sys_clk);
    cmd_sel = s;
    cmd_rd = 1'b1;
    @(negedge sys_clk);
    cmd_rd = 1'b0;
    @(negedge sys_clk);
    d = rdata;
  endtask

  task automatic clr;
    @(negedge sys_clk);
    clr_status = 1'b1;
    @(negedge sys_clk);
    clr_status = 1'b0;
  endtask
endmodule

// File: cssg_pkg.sv
// package: register selectors, bit positions and reset values of the signalling status group
package cssg_pkg;
  localparam int unsigned CSSG_WIDTH = 16;

  // register selectors on the command port
  typedef enum logic [2:0] {
    CSSG_SEL_COND,
    CSSG_SEL_PTR,
    CSSG_SEL_NTR,
    CSSG_SEL_EVENT,
    CSSG_SEL_ENABLE
  } cssg_sel_t;

  localparam int unsigned CSSG_BIT_RSVD      = 15;
  localparam int unsigned CSSG_BIT_RAMP      = 14;
  localparam int unsigned CSSG_BIT_FER_RPT   = 13;
  localparam int unsigned CSSG_BIT_PILOT     = 12;
  localparam int unsigned CSSG_BIT_REGD      = 11;
  localparam int unsigned CSSG_BIT_FER_PASS  = 10;
  localparam int unsigned CSSG_BIT_FER_FAIL  = 9;
  localparam int unsigned CSSG_BIT_FER_MAX   = 8;
  localparam int unsigned CSSG_BIT_SO2       = 7;
  localparam int unsigned CSSG_BIT_HARD_HO   = 6;
  localparam int unsigned CSSG_BIT_SOFTER_HO = 5;
  localparam int unsigned CSSG_BIT_ALERT     = 4;
  localparam int unsigned CSSG_BIT_CONNECTED = 3;
  localparam int unsigned CSSG_BIT_CELL_TX   = 2;
  localparam int unsigned CSSG_BIT_PAGE_SENT = 1;
  localparam int unsigned CSSG_BIT_ACCESS    = 0;

  // bits with a live condition behind them; bits 13 to 8 are event-only, bit 15 is reserved
  localparam logic [15:0] CSSG_COND_MASK  = 16'h40FF;
  localparam logic [15:0] CSSG_EVONLY_MASK = 16'h3F00;
  localparam logic [15:0] CSSG_PTR_RESET  = 16'h7FFF;
  localparam logic [15:0] CSSG_NTR_RESET  = 16'h0000;
  localparam logic [15:0] CSSG_ENA_RESET  = 16'h0000;
  localparam logic [15:0] CSSG_EVT_RESET  = 16'h0000;
  localparam logic [15:0] CSSG_COND_RESET = 16'h0000;
endpackage

// File: cssg_top.sv
// top: signalling status group with condition inputs, event strobes and command port
module cssg_top
  import cssg_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // live conditions
  input  wire logic        ramping,
  input  wire logic        so2_connected,
  input  wire logic        hard_handoff,
  input  wire logic        softer_handoff,
  input  wire logic        alerting,
  input  wire logic        call_connected,
  input  wire logic        spread_mode,
  input  wire logic        call_start,
  input  wire logic        access_probe,
  input  wire logic        call_end,
  // event-only strobes
  input  wire logic        fer_reported,
  input  wire logic        pilot_msg,
  input  wire logic        registering,
  input  wire logic        fer_pass,
  input  wire logic        fer_fail,
  input  wire logic        fer_max_frames,
  // command port
  input  wire logic        cmd_wr,
  input  wire logic        cmd_rd,
  input  wire cssg_sel_t   cmd_sel,
  input  wire logic [15:0] cmd_wdata,
  input  wire logic        clr_status,
  // answers
  output logic [15:0]      rdata,
  output logic             group_summary_bit
);
  logic page_sent;
  logic probe_seen;
  logic registering_q;

  cssg_cmd_if cmd ();

  // page-sent and access-probe conditions hold until the call ends
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      page_sent <= 1'b0;
    end else if (call_start) begin
      page_sent <= 1'b1;
    end else if (call_end) begin
      page_sent <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      probe_seen <= 1'b0;
    end else if (access_probe) begin
      probe_seen <= 1'b1;
    end else if (call_end) begin
      probe_seen <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      registering_q <= 1'b0;
    end else begin
      registering_q <= registering;
    end
  end

  always_comb begin
    cmd.cond = 16'h0000;
    cmd.cond[CSSG_BIT_RAMP]      = ramping;
    cmd.cond[CSSG_BIT_SO2]       = so2_connected;
    cmd.cond[CSSG_BIT_HARD_HO]   = hard_handoff;
    cmd.cond[CSSG_BIT_SOFTER_HO] = softer_handoff;
    cmd.cond[CSSG_BIT_ALERT]     = alerting;
    cmd.cond[CSSG_BIT_CONNECTED] = call_connected;
    cmd.cond[CSSG_BIT_CELL_TX]   = spread_mode;
    cmd.cond[CSSG_BIT_PAGE_SENT] = page_sent;
    cmd.cond[CSSG_BIT_ACCESS]    = probe_seen;
    cmd.event_only = 16'h0000;
    cmd.event_only[CSSG_BIT_FER_RPT]  = fer_reported;
    cmd.event_only[CSSG_BIT_PILOT]    = pilot_msg;
    cmd.event_only[CSSG_BIT_REGD]     = registering_q & ~registering;
    cmd.event_only[CSSG_BIT_FER_PASS] = fer_pass;
    cmd.event_only[CSSG_BIT_FER_FAIL] = fer_fail;
    cmd.event_only[CSSG_BIT_FER_MAX]  = fer_max_frames;
  end

  assign cmd.wr         = cmd_wr;
  assign cmd.rd         = cmd_rd;
  assign cmd.sel        = cmd_sel;
  assign cmd.wdata      = cmd_wdata;
  assign cmd.clr_status = clr_status;
  assign rdata             = cmd.rdata;
  assign group_summary_bit = cmd.summary;

  cssg_core u_core (
    .sys_clk (sys_clk),
    .rst     (rst),
    .cmd     (cmd.core)
  );

  a_page_hold: assert property (@(posedge sys_clk) disable iff (rst)
    call_start |=> page_sent)
    else $error("page sent not set on call start");
  a_probe_end: assert property (@(posedge sys_clk) disable iff (rst)
    (call_end && !access_probe) |=> !probe_seen)
    else $error("access probe not cleared at call end");
endmodule

// File: tb_top.sv
// testbench: status commands and condition stimulus against the signalling status group
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin err_count++; $display("unexpected %s exp %h got %h", n, e, g); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import cssg_pkg::*;

  logic        sys_clk, rst, call_start, access_probe, call_end, clr_status, cmd_wr, cmd_rd, group_summary_bit;
  logic [6:0]  lv;
  logic [5:0]  ev;
  logic [15:0] cmd_wdata, rdata, v;
  cssg_sel_t   cmd_sel;
  int          err_count, comparisons;

  cssg_top u_dut (.sys_clk(sys_clk), .rst(rst), .ramping(lv[6]), .so2_connected(lv[5]), .hard_handoff(lv[4]),
    .softer_handoff(lv[3]), .alerting(lv[2]), .call_connected(lv[1]), .spread_mode(lv[0]),
    .call_start(call_start), .access_probe(access_probe), .call_end(call_end), .fer_reported(ev[5]),
    .pilot_msg(ev[4]), .registering(ev[3]), .fer_pass(ev[2]), .fer_fail(ev[1]), .fer_max_frames(ev[0]),
    .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_sel(cmd_sel), .cmd_wdata(cmd_wdata), .clr_status(clr_status),
    .rdata(rdata), .group_summary_bit(group_summary_bit));
  cssg_ctrl_model u_ctrl (.sys_clk(sys_clk), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_sel(cmd_sel),
    .cmd_wdata(cmd_wdata), .clr_status(clr_status), .rdata(rdata));

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  task automatic final_report;
    $display("checks %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic rd_chk(input cssg_sel_t s, input logic [15:0] e, input string n);
    u_ctrl.rd_reg(s, v);
    `CHK(n, e, v)
  endtask

  // all event-only sources fire once; the registered bit latches one cycle later, on the fall of registering
  task automatic strobe_all;
    @(negedge sys_clk);
    ev = 6'h3F;
    @(negedge sys_clk);
    ev = 6'h00;
    repeat (2) @(negedge sys_clk);
  endtask

  initial begin
    {lv, ev, call_start, access_probe, call_end} = '0;
    rst = 1'b1;
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
    rst = 1'b0;
    rd_chk(CSSG_SEL_PTR, 16'h7FFF, "ptr reset");
    rd_chk(CSSG_SEL_NTR, 16'h0000, "ntr reset");
    rd_chk(CSSG_SEL_ENABLE, 16'h0000, "enable reset");
    rd_chk(CSSG_SEL_EVENT, 16'h0000, "event reset");
    rd_chk(CSSG_SEL_COND, 16'h0000, "cond reset");
    $display("test reset values done");
    u_ctrl.wr_reg(CSSG_SEL_PTR, 16'hFFFF);
    u_ctrl.wr_reg(CSSG_SEL_NTR, 16'hFFFF);
    u_ctrl.wr_reg(CSSG_SEL_ENABLE, 16'hFFFF);
    u_ctrl.wr_reg(CSSG_SEL_COND, 16'hFFFF);
    rd_chk(CSSG_SEL_PTR, 16'h7FFF, "ptr write");
    rd_chk(CSSG_SEL_NTR, 16'h7FFF, "ntr write");
    rd_chk(CSSG_SEL_ENABLE, 16'h7FFF, "enable write");
    rd_chk(CSSG_SEL_COND, 16'h0000, "cond write ignored");
    u_ctrl.wr_reg(CSSG_SEL_NTR, 16'h4001);
    u_ctrl.wr_reg(CSSG_SEL_ENABLE, 16'h0000);
    $display("test register access done");
    @(negedge sys_clk);
    lv = 7'h7F;
    call_start = 1'b1;
    access_probe = 1'b1;
    @(negedge sys_clk);
    call_start = 1'b0;
    access_probe = 1'b0;
    rd_chk(CSSG_SEL_COND, 16'h40FF, "cond all set");
    rd_chk(CSSG_SEL_COND, 16'h40FF, "cond reread");
    rd_chk(CSSG_SEL_EVENT, 16'h40FF, "rising events");
    rd_chk(CSSG_SEL_EVENT, 16'h0000, "event cleared by query");
    @(negedge sys_clk);
    call_end = 1'b1;
    lv[6] = 1'b0;
    @(negedge sys_clk);
    call_end = 1'b0;
    rd_chk(CSSG_SEL_COND, 16'h00FC, "cond after call end");
    rd_chk(CSSG_SEL_EVENT, 16'h4001, "filtered falling events");
    $display("test conditions done");
    strobe_all();
    rd_chk(CSSG_SEL_EVENT, 16'h3F00, "event only bits");
    strobe_all();
    `CHK("summary masked", 1'b0, group_summary_bit)
    u_ctrl.wr_reg(CSSG_SEL_ENABLE, 16'h0100);
    repeat (2) @(negedge sys_clk);
    `CHK("summary enabled", 1'b1, group_summary_bit)
    u_ctrl.clr();
    repeat (2) @(negedge sys_clk);
    `CHK("summary after clear", 1'b0, group_summary_bit)
    rd_chk(CSSG_SEL_EVENT, 16'h0000, "event after clear");
    $display("test events and summary done");
    final_report();
  end

  initial begin
    #100us;
    err_count++;
    $display("watchdog expired");
    final_report();
  end
endmodule
